// file: design/sttd_pkg.sv
// constants, field layouts and carrier types of the scan time-down timer bank
// assumes a 10 MHz register clock and an APB master with 32-bit data
package sttd_pkg;

  // bank geometry
  localparam int NUM_TIMERS = 32;
  localparam int HS_TIMERS = 16;
  localparam int NUM_DREGS = 100;
  localparam int HS_DREGS = 32;
  localparam logic [13:0] PRESET_MAX = 14'h270F;
  localparam logic [15:0] DREG_PRESET_MAX = 16'h270F;

  // timebase
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_1MS_NS = 1000000;
  localparam int TICK_1MS_CYCLES = TICK_1MS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam logic [3:0] RELAY_HALF = 4'h5;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IN_IMG = 12'h008;
  localparam logic [11:0] ADDR_OUT_IMG = 12'h00C;
  localparam logic [11:0] ADDR_REF = 12'h010;
  localparam logic [11:0] ADDR_CFG_BASE = 12'h080;
  localparam logic [11:0] ADDR_PRESET_BASE = 12'h100;
  localparam logic [11:0] ADDR_COUNT_BASE = 12'h180;
  localparam logic [11:0] ADDR_DREG_BASE = 12'h200;

  // field positions
  localparam int CTRL_HS_BIT = 0;
  localparam int CTRL_SCAN_END_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam int STAT_PERR_BIT = 0;
  localparam int STAT_DUP_BIT = 1;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_SRC_BIT = 1;
  localparam int CFG_BASE_LSB = 2;

  // reset values
  localparam logic RST_HS = 1'b0;
  localparam logic [13:0] RST_PRESET = 14'h0000;
  localparam logic [15:0] RST_DREG = 16'h0000;

  typedef enum logic [1:0] {
    STTD_BASE_100MS = 2'b00,
    STTD_BASE_10MS = 2'b01,
    STTD_BASE_1MS = 2'b10
  } sttd_base_t;

  typedef enum logic [3:0] {
    STTD_REG_NONE = 4'b0000,
    STTD_REG_CTRL = 4'b0001,
    STTD_REG_STATUS = 4'b0010,
    STTD_REG_IN_IMG = 4'b0011,
    STTD_REG_OUT_IMG = 4'b0100,
    STTD_REG_REF = 4'b0101,
    STTD_REG_CFG = 4'b0110,
    STTD_REG_PRESET = 4'b0111,
    STTD_REG_COUNT = 4'b1000,
    STTD_REG_DREG = 4'b1001
  } sttd_reg_t;

  typedef struct packed {
    logic en;
    logic src_dr;
    logic [1:0] base;
  } sttd_cfg_t;

  typedef struct packed {
    sttd_reg_t kind;
    logic [6:0] idx;
  } sttd_dec_t;

  typedef struct packed {
    logic one_second;
    logic tenth_second;
    logic hundredth_second;
  } sttd_relay_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } sttd_apb_req_t;

endpackage : sttd_pkg

// file: design/sttd_timer_bank.sv
// bank of preset time-down timers for a scanned controller, with APB registers
// assumes timer inputs arrive asynchronously on pins; software marks end of scan
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sttd_timer_bank #(
  parameter int unsigned TICK_CYCLES = sttd_pkg::TICK_1MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // timer pins
  input wire logic [31:0] timer_in_i,
  output logic [31:0] timer_out_o,
  // error and clock relays
  output logic error_indicator_lamp_o,
  output logic program_error_relay_o,
  output logic one_second_clock_relay_o,
  output logic tenth_second_clock_relay_o,
  output logic hundredth_second_clock_relay_o
);

  typedef struct packed {
    logic [31:0] in_meta;
    logic [31:0] in_sync;
    logic [31:0] in_img;
    logic [31:0] timer_out;
    logic [31:0] done;
    logic hs;
    logic perr;
    logic dup;
    logic [13:0] presc;
    logic [15:0] ref_ms;
    logic [3:0] d10;
    logic [3:0] d100;
    logic [3:0] d1000;
    sttd_pkg::sttd_relay_t relay;
    sttd_pkg::sttd_cfg_t [31:0] cfg;
    logic [31:0][13:0] preset;
    logic [31:0][13:0] count;
    logic [99:0][15:0] dreg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sttd_state_t;

  sttd_state_t st_reg;
  sttd_state_t st_next;

  // address decode shared by the read and write phases
  function automatic sttd_pkg::sttd_dec_t decode(input logic [11:0] a, input logic hs);
    sttd_pkg::sttd_dec_t d;
    logic [11:0] off;
    d.kind = sttd_pkg::STTD_REG_NONE;
    off = 12'h000;
    d.idx = a[8:2];
    if (a[1:0] != 2'b00) begin
      d.kind = sttd_pkg::STTD_REG_NONE;
    end else if (a == sttd_pkg::ADDR_CTRL) begin
      d.kind = sttd_pkg::STTD_REG_CTRL;
    end else if (a == sttd_pkg::ADDR_STATUS) begin
      d.kind = sttd_pkg::STTD_REG_STATUS;
    end else if (a == sttd_pkg::ADDR_IN_IMG) begin
      d.kind = sttd_pkg::STTD_REG_IN_IMG;
    end else if (a == sttd_pkg::ADDR_OUT_IMG) begin
      d.kind = sttd_pkg::STTD_REG_OUT_IMG;
    end else if (a == sttd_pkg::ADDR_REF) begin
      d.kind = sttd_pkg::STTD_REG_REF;
    end else if (a >= sttd_pkg::ADDR_CFG_BASE && a < sttd_pkg::ADDR_PRESET_BASE) begin
      d.kind = sttd_pkg::STTD_REG_CFG;
      d.idx = {2'b00, a[6:2]};
    end else if (a >= sttd_pkg::ADDR_PRESET_BASE && a < sttd_pkg::ADDR_COUNT_BASE) begin
      d.kind = sttd_pkg::STTD_REG_PRESET;
      d.idx = {2'b00, a[6:2]};
    end else if (a >= sttd_pkg::ADDR_COUNT_BASE && a < sttd_pkg::ADDR_DREG_BASE) begin
      d.kind = sttd_pkg::STTD_REG_COUNT;
      d.idx = {2'b00, a[6:2]};
    end else if (a >= sttd_pkg::ADDR_DREG_BASE) begin
      off = 12'((a - sttd_pkg::ADDR_DREG_BASE) >> 2);
      // range test on the whole index, so high addresses do not wrap onto low registers
      if (off < (hs ? 12'(sttd_pkg::HS_DREGS) : 12'(sttd_pkg::NUM_DREGS))) begin
        d.kind = sttd_pkg::STTD_REG_DREG;
        d.idx = off[6:0];
      end
    end
    return d;
  endfunction : decode

  // one step of a decimal divider stage
  function automatic logic [3:0] decade_step(input logic [3:0] d);
    return (d == sttd_pkg::DECADE_LAST) ? 4'h0 : 4'(d + 4'h1);
  endfunction : decade_step

  // effective preset of one timer, with its out-of-range flag
  function automatic logic [14:0] resolve(input sttd_pkg::sttd_cfg_t c, input logic [13:0] p,
                                          input logic [99:0][15:0] dr, input logic hs);
    logic [15:0] v;
    logic bad;
    v = 16'h0000;
    bad = 1'b0;
    if (c.src_dr) begin
      if (p >= (hs ? 14'(sttd_pkg::HS_DREGS) : 14'(sttd_pkg::NUM_DREGS))) begin
        bad = 1'b1;
      end else begin
        v = dr[p[6:0]];
        bad = v > sttd_pkg::DREG_PRESET_MAX;
      end
    end else begin
      v = {2'b00, p};
    end
    return {bad, v[13:0]};
  endfunction : resolve

  sttd_pkg::sttd_apb_req_t req;
  assign req = '{paddr: paddr_i, psel: psel_i, penable: penable_i, pwrite: pwrite_i, pwdata: pwdata_i};

  always_comb begin
    sttd_pkg::sttd_dec_t dec;
    logic tick1;
    logic tick10;
    logic tick100;
    logic step;
    logic active;
    logic [14:0] rp;
    logic perr_set;
    logic dup_set;
    logic err_clr;
    logic wr;
    dec = decode(req.paddr, st_reg.hs);
    // free-running timebases, not aligned to the scan in any way
    tick1 = st_reg.presc == 14'(TICK_CYCLES - 1);
    tick10 = tick1 && st_reg.d10 == sttd_pkg::DECADE_LAST;
    tick100 = tick10 && st_reg.d100 == sttd_pkg::DECADE_LAST;
    wr = 1'b0;
    st_next = st_reg;
    perr_set = 1'b0;
    dup_set = 1'b0;
    err_clr = 1'b0;
    step = 1'b0;
    active = 1'b0;
    rp = 15'h0000;

    // pin synchroniser; only the second stage is read below
    st_next.in_meta = timer_in_i;
    st_next.in_sync = st_reg.in_meta;

    st_next.presc = tick1 ? 14'h0000 : 14'(st_reg.presc + 14'h0001);
    if (tick1) begin
      st_next.ref_ms = 16'(st_reg.ref_ms + 16'h0001);
      st_next.d10 = decade_step(st_reg.d10);
    end
    if (tick10) begin
      st_next.d100 = decade_step(st_reg.d100);
    end
    if (tick100) begin
      st_next.d1000 = decade_step(st_reg.d1000);
    end
    // square-wave clock relays for building retentive timing with a counter
    st_next.relay.hundredth_second = st_next.d10 >= sttd_pkg::RELAY_HALF;
    st_next.relay.tenth_second = st_next.d100 >= sttd_pkg::RELAY_HALF;
    st_next.relay.one_second = st_next.d1000 >= sttd_pkg::RELAY_HALF;

    // timer evaluation against the sampled input image
    for (int n = 0; n < sttd_pkg::NUM_TIMERS; n++) begin
      active = st_reg.cfg[n].en && !(st_reg.hs && n >= sttd_pkg::HS_TIMERS);
      rp = resolve(st_reg.cfg[n], st_reg.preset[n], st_reg.dreg, st_reg.hs);
      unique case (st_reg.cfg[n].base)
        sttd_pkg::STTD_BASE_100MS: step = tick100;
        sttd_pkg::STTD_BASE_10MS: step = tick10;
        sttd_pkg::STTD_BASE_1MS: step = tick1;
        default: step = tick1;
      endcase
      if (!active) begin
        st_next.count[n] = rp[13:0];
        st_next.done[n] = 1'b0;
      end else if (rp[14]) begin
        // bad preset holds the count at zero with done low
        perr_set = 1'b1;
        st_next.count[n] = 14'h0000;
        st_next.done[n] = 1'b0;
      end else if (!st_reg.in_img[n]) begin
        st_next.count[n] = rp[13:0];
        st_next.done[n] = 1'b0;
      end else if (rp[13:0] == 14'h0000) begin
        st_next.count[n] = 14'h0000;
        st_next.done[n] = 1'b1;
      end else begin
        // count was loaded at reload, so a new valid non-zero preset waits for the next run
        if (step && st_reg.count[n] != 14'h0000) begin
          st_next.count[n] = 14'(st_reg.count[n] - 14'h0001);
        end
        st_next.done[n] = st_next.count[n] == 14'h0000;
      end
    end

    // apb: answer is prepared in setup and presented in the access phase
    if (req.psel && !req.penable) begin
      st_next.pready = 1'b1;
      st_next.pslverr = dec.kind == sttd_pkg::STTD_REG_NONE;
      st_next.prdata = 32'h00000000;
      unique case (dec.kind)
        sttd_pkg::STTD_REG_CTRL: st_next.prdata[sttd_pkg::CTRL_HS_BIT] = st_reg.hs;
        sttd_pkg::STTD_REG_STATUS: begin
          st_next.prdata[sttd_pkg::STAT_PERR_BIT] = st_reg.perr;
          st_next.prdata[sttd_pkg::STAT_DUP_BIT] = st_reg.dup;
        end
        sttd_pkg::STTD_REG_IN_IMG: st_next.prdata = st_reg.in_img;
        sttd_pkg::STTD_REG_OUT_IMG: st_next.prdata = st_reg.done;
        sttd_pkg::STTD_REG_REF: st_next.prdata = {16'h0000, st_reg.ref_ms};
        sttd_pkg::STTD_REG_CFG: begin
          // register field order differs from the packing of the struct
          st_next.prdata = {28'h0000000, st_reg.cfg[dec.idx[4:0]].base,
                            st_reg.cfg[dec.idx[4:0]].src_dr, st_reg.cfg[dec.idx[4:0]].en};
        end
        sttd_pkg::STTD_REG_PRESET: st_next.prdata = {18'h00000, st_reg.preset[dec.idx[4:0]]};
        sttd_pkg::STTD_REG_COUNT: st_next.prdata = {18'h00000, st_reg.count[dec.idx[4:0]]};
        sttd_pkg::STTD_REG_DREG: st_next.prdata = {16'h0000, st_reg.dreg[dec.idx]};
        default: st_next.prdata = 32'h00000000;
      endcase
    end else if (req.psel && req.penable && st_reg.pready) begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      wr = req.pwrite && !st_reg.pslverr;
    end else begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
    end

    if (wr) begin
      unique case (dec.kind)
        sttd_pkg::STTD_REG_CTRL: begin
          st_next.hs = req.pwdata[sttd_pkg::CTRL_HS_BIT];
          err_clr = req.pwdata[sttd_pkg::CTRL_CLR_BIT];
          if (req.pwdata[sttd_pkg::CTRL_SCAN_END_BIT]) begin
            st_next.in_img = st_reg.in_sync;
            // timer results go straight into the output image
            st_next.timer_out = st_reg.done;
          end
        end
        sttd_pkg::STTD_REG_CFG: begin
          if (req.pwdata[sttd_pkg::CFG_EN_BIT] &&
              (st_reg.cfg[dec.idx[4:0]].en || (st_reg.hs && dec.idx >= 7'(sttd_pkg::HS_TIMERS)))) begin
            dup_set = 1'b1;
          end else begin
            st_next.cfg[dec.idx[4:0]].en = req.pwdata[sttd_pkg::CFG_EN_BIT];
            st_next.cfg[dec.idx[4:0]].src_dr = req.pwdata[sttd_pkg::CFG_SRC_BIT];
            st_next.cfg[dec.idx[4:0]].base = req.pwdata[sttd_pkg::CFG_BASE_LSB +: 2];
          end
        end
        sttd_pkg::STTD_REG_PRESET: begin
          // for a direct preset the whole word is tested so upper bits cannot alias a legal preset
          if (!st_reg.cfg[dec.idx[4:0]].src_dr && req.pwdata > 32'(sttd_pkg::PRESET_MAX)) begin
            perr_set = 1'b1;
          end else begin
            st_next.preset[dec.idx[4:0]] = req.pwdata[13:0];
          end
        end
        sttd_pkg::STTD_REG_DREG: st_next.dreg[dec.idx] = req.pwdata[15:0];
        default: st_next.hs = st_reg.hs;
      endcase
    end

    // sticky errors: a new event beats a simultaneous clear
    st_next.perr = (st_reg.perr && !err_clr) || perr_set;
    st_next.dup = (st_reg.dup && !err_clr) || dup_set;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
      st_reg.hs <= sttd_pkg::RST_HS;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata_o = st_reg.prdata;
  assign pready_o = st_reg.pready;
  assign pslverr_o = st_reg.pslverr;
  assign timer_out_o = st_reg.timer_out;
  assign error_indicator_lamp_o = st_reg.perr;
  assign program_error_relay_o = st_reg.perr;
  assign one_second_clock_relay_o = st_reg.relay.one_second;
  assign tenth_second_clock_relay_o = st_reg.relay.tenth_second;
  assign hundredth_second_clock_relay_o = st_reg.relay.hundredth_second;

endmodule : sttd_timer_bank
`default_nettype wire

// file: dv/sttd_monitor.sv
// port checker of the timer bank: bus handshake, scan-bound pins, error relay, clock relay
// bound onto every sttd_timer_bank; TICK_CYCLES is handed on from the instance
`timescale 1ns/1ns
`default_nettype none
module sttd_monitor #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // apb
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins
  input wire logic [31:0] timer_out_o,
  input wire logic error_indicator_lamp_o,
  input wire logic program_error_relay_o,
  input wire logic one_second_clock_relay_o,
  input wire logic tenth_second_clock_relay_o,
  input wire logic hundredth_second_clock_relay_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic ctrl_wr;
  logic rel_q;
  logic seen_q;
  logic [31:0] gap_q;
  assign ctrl_wr = psel_i && penable_i && pwrite_i && pready_o && paddr_i == sttd_pkg::ADDR_CTRL;
  // first relay edge after reset is skipped: its phase depends on the release
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rel_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q <= 32'h0;
    end else begin
      rel_q <= hundredth_second_clock_relay_o;
      gap_q <= (rel_q != hundredth_second_clock_relay_o) ? 32'h0 : gap_q + 32'h1;
      seen_q <= seen_q || (rel_q != hundredth_second_clock_relay_o);
    end
  end
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("ready longer than a cycle");
  a_ready_unasked: assert property (pready_o |-> $past(psel_i && !penable_i)) else $error("ready without setup");
  a_err_data_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error answer");
  a_out_at_scan: assert property (!$stable(timer_out_o) |-> $past(ctrl_wr && pwdata_i[1]) ||
    $past(ctrl_wr && pwdata_i[1], 2)) else $error("outputs moved outside scan end");
  a_lamp_with_relay: assert property (error_indicator_lamp_o == program_error_relay_o)
    else $error("lamp and relay differ");
  a_error_sticky: assert property ($fell(program_error_relay_o) |-> $past(ctrl_wr && pwdata_i[2]) ||
    $past(ctrl_wr && pwdata_i[2], 2)) else $error("error relay dropped uncleared");
  a_relay_half_period: assert property (seen_q && rel_q != hundredth_second_clock_relay_o
    |-> gap_q == 5 * TICK_CYCLES - 1) else $error("clock relay half period wrong");
  a_tenth_on_hundredth: assert property ($changed(tenth_second_clock_relay_o)
    |-> $fell(hundredth_second_clock_relay_o)) else $error("tenth relay moved off a hundredth period end");
  a_second_on_tenth: assert property ($changed(one_second_clock_relay_o)
    |-> $fell(tenth_second_clock_relay_o)) else $error("second relay moved off a tenth period end");
  c_scan: cover property (ctrl_wr && pwdata_i[1]);
  c_one_second: cover property ($rose(one_second_clock_relay_o));
  c_error: cover property ($rose(program_error_relay_o));
  c_slverr: cover property (pslverr_o);
endmodule : sttd_monitor
bind sttd_timer_bank sttd_monitor #(.TICK_CYCLES(TICK_CYCLES)) sttd_monitor_inst (.*);
`default_nettype wire

// file: dv/sttd_apb.sv
// apb master standing in for the scan program that reaches the timer bank
// waits for pready as long as it takes; only the bench timeout ends a hang
`timescale 1ns/1ns
`default_nettype none
module sttd_apb (
  // clock
  input wire logic ref_clk_i,
  // request
  output logic [11:0] paddr_o,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [31:0] pwdata_o,
  // answer
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  initial begin
    paddr_o = 12'h000;
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    pwdata_o = 32'h0;
  end
  // an idle edge ends each transfer so psel is never driven twice in a step
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rdata, output logic err);
    @(posedge ref_clk_i);
    paddr_o <= a;
    pwrite_o <= wr;
    pwdata_o <= d;
    psel_o <= 1'b1;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    // pready is taken at the rising edge that completes the access
    do begin
      @(posedge ref_clk_i);
    end while (pready_i !== 1'b1);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d;
  endtask : xfer
endmodule : sttd_apb
`default_nettype wire

// file: dv/scan_timedown_timers_test.sv
// self-checking bench of the timer bank through its apb registers and timer pins
// assumes the ms tick shortened to TICK clocks
`timescale 1ns/1ns
`default_nettype none
module scan_timedown_timers_test;
  localparam int unsigned TICK = 20;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [31:0] tin = 32'h0;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] tout;
  logic lamp;
  logic perr;
  logic [31:0] rv;
  logic re;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int per;
  always #50 ref_clk_i = ~ref_clk_i;
  sttd_apb sttd_apb_inst (.ref_clk_i(ref_clk_i), .paddr_o(paddr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  sttd_timer_bank #(.TICK_CYCLES(TICK)) sttd_timer_bank_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .timer_in_i(tin), .timer_out_o(tout),
    .error_indicator_lamp_o(lamp), .program_error_relay_o(perr), .one_second_clock_relay_o(),
    .tenth_second_clock_relay_o(), .hundredth_second_clock_relay_o());
  function automatic logic [11:0] at(input logic [11:0] b, input int n);
    return b + 12'(4 * n);
  endfunction : at
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    sttd_apb_inst.xfer(1'b1, a, d, rv, re);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    sttd_apb_inst.xfer(1'b0, a, 32'h0, rv, re);
    chk(exp, rv);
  endtask : rd
  // pin change, synchroniser delay, then end of scan
  task automatic feed(input int n, input logic v);
    @(posedge ref_clk_i) tin[n] <= v;
    repeat (3) @(posedge ref_clk_i);
    wr(sttd_pkg::ADDR_CTRL, 32'h2);
  endtask : feed
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(at(sttd_pkg::ADDR_COUNT_BASE, 0), 32'h0);
    rd(sttd_pkg::ADDR_STATUS, 32'h0);
    chk(32'h0, tout);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 1), 32'h3);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 1), 32'h9);
    @(posedge ref_clk_i) tin[1] <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(sttd_pkg::ADDR_IN_IMG, 32'h0);
    wr(sttd_pkg::ADDR_CTRL, 32'h2);
    rd(sttd_pkg::ADDR_IN_IMG, 32'h2);
    repeat (100) @(posedge ref_clk_i);
    rd(sttd_pkg::ADDR_OUT_IMG, 32'h2);
    rd(at(sttd_pkg::ADDR_COUNT_BASE, 1), 32'h0);
    chk(32'h0, tout);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 1), 32'h5);
    rd(at(sttd_pkg::ADDR_COUNT_BASE, 1), 32'h0);
    wr(sttd_pkg::ADDR_CTRL, 32'h2);
    repeat (2) @(negedge ref_clk_i);
    chk(32'h2, tout);
    feed(1, 1'b0);
    rd(at(sttd_pkg::ADDR_COUNT_BASE, 1), 32'h5);
    rd(sttd_pkg::ADDR_OUT_IMG, 32'h0);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 1), 32'h9);
    rd(sttd_pkg::ADDR_STATUS, 32'h2);
    wr(sttd_pkg::ADDR_CTRL, 32'h4);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 31), 32'h9);
    rd(at(sttd_pkg::ADDR_CFG_BASE, 31), 32'h9);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 31), 32'h0);
    wr(sttd_pkg::ADDR_CTRL, 32'h1);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 20), 32'h9);
    rd(at(sttd_pkg::ADDR_CFG_BASE, 20), 32'h0);
    rd(sttd_pkg::ADDR_STATUS, 32'h2);
    wr(sttd_pkg::ADDR_CTRL, 32'h4);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 5), 32'h2710);
    rd(at(sttd_pkg::ADDR_PRESET_BASE, 5), 32'h0);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 5), 32'h4001);
    rd(at(sttd_pkg::ADDR_PRESET_BASE, 5), 32'h0);
    rd(sttd_pkg::ADDR_STATUS, 32'h1);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 5), 32'h270F);
    rd(at(sttd_pkg::ADDR_PRESET_BASE, 5), 32'h270F);
    wr(sttd_pkg::ADDR_CTRL, 32'h4);
    wr(at(sttd_pkg::ADDR_DREG_BASE, 10), 32'hFFFF);
    rd(at(sttd_pkg::ADDR_DREG_BASE, 10), 32'hFFFF);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 4), 32'hA);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 4), 32'hB);
    feed(4, 1'b1);
    repeat (2) @(negedge ref_clk_i);
    chk(32'h1, {31'h0, perr});
    chk(32'h1, {31'h0, lamp});
    wr(at(sttd_pkg::ADDR_DREG_BASE, 10), 32'h2);
    wr(sttd_pkg::ADDR_CTRL, 32'h4);
    rd(sttd_pkg::ADDR_STATUS, 32'h0);
    repeat (80) @(posedge ref_clk_i);
    rd(sttd_pkg::ADDR_OUT_IMG, 32'h10);
    wr(sttd_pkg::ADDR_CTRL, 32'h1);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 4), 32'h28);
    rd(sttd_pkg::ADDR_STATUS, 32'h1);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 4), 32'h0);
    wr(sttd_pkg::ADDR_CTRL, 32'h4);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 3), 32'h9);
    wr(at(sttd_pkg::ADDR_CFG_BASE, 3), 32'h1);
    feed(3, 1'b1);
    wr(at(sttd_pkg::ADDR_PRESET_BASE, 3), 32'h0);
    rd(sttd_pkg::ADDR_OUT_IMG, 32'h8);
    for (int b = 0; b < 4; b++) begin
      per = (b == 0) ? 100 * TICK : (b == 1) ? 10 * TICK : TICK;
      wr(at(sttd_pkg::ADDR_PRESET_BASE, 2), 32'h2);
      wr(at(sttd_pkg::ADDR_CFG_BASE, 2), 32'h1 | 32'(b << 2));
      feed(2, 1'b1);
      repeat (per - 6) @(posedge ref_clk_i);
      rd(sttd_pkg::ADDR_OUT_IMG, 32'h8);
      repeat (per + 10) @(posedge ref_clk_i);
      rd(sttd_pkg::ADDR_OUT_IMG, 32'hC);
      feed(2, 1'b0);
      wr(at(sttd_pkg::ADDR_CFG_BASE, 2), 32'h0);
    end
    sttd_apb_inst.xfer(1'b0, 12'hFFC, 32'h0, rv, re);
    chk(32'h0, rv);
    chk(32'h1, {31'h0, re});
    // index past the last data register must not wrap onto a low one
    sttd_apb_inst.xfer(1'b0, at(sttd_pkg::ADDR_DREG_BASE, 128), 32'h0, rv, re);
    chk(32'h1, {31'h0, re});
    // let the slowest clock relay toggle twice under the monitor
    repeat (1000 * TICK) @(posedge ref_clk_i);
    tally_and_finish();
  end
endmodule : scan_timedown_timers_test
`default_nettype wire
